// >>> bench/tp_link_chk_props.sv
`timescale 1ns/1ps
`include "tp_link_cfg.svh"
module tp_link_chk #(
  parameter int LINK_RX_MIN_CYC = 10,
  parameter int LINK_RX_MAX_CYC = 100,
  parameter int LED_HOLD_CYC    = 50
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_rx_link_pulse,
  input wire logic i_rx_activity,
  input wire logic i_collision,
  input wire logic o_tp_out_pos_main,
  input wire logic o_tp_out_neg_main,
  input wire logic o_tp_out_pos_predist,
  input wire logic o_link_good,
  input wire logic o_sqe,
  input wire logic o_led_col
);
  int quiet_q, sqe_q, col_q, pul_q, act_q;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      quiet_q <= 0;
      sqe_q   <= 0;
      col_q   <= 0;
      pul_q   <= 1000;
      act_q   <= 0;
    end else begin
      quiet_q <= (o_tp_out_pos_main | o_tp_out_neg_main) ? 0 : quiet_q + 1;
      sqe_q   <= o_sqe ? sqe_q + 1 : 0;
      col_q   <= o_led_col ? col_q + 1 : 0;
      pul_q   <= i_rx_link_pulse ? 0 : pul_q + 1;
      act_q   <= (i_rx_link_pulse | i_rx_activity) ? 0 : act_q + 1;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence early_pulse;
    i_rx_link_pulse && pul_q < LINK_RX_MIN_CYC - 3;
  endsequence
  sequence col_start;
    $rose(i_collision);
  endsequence
  chk_pre_pos_follow: assert property ($rose(o_tp_out_pos_predist) |-> $past(o_tp_out_pos_main))
    else $error("predistortion rose without main");
  chk_line_mutex: assert property (!(o_tp_out_pos_main && o_tp_out_neg_main))
    else $error("both line outputs high");
  chk_sqe_len: assert property ($fell(o_sqe) |-> sqe_q == `SQE_WIN_CYC)
    else $error("sqe window length wrong");
  chk_sqe_wait: assert property ($rose(o_sqe) |-> quiet_q >= 16 && quiet_q <= 24)
    else $error("sqe wait length wrong");
  chk_col_led_on: assert property (col_start |-> ##[1:2] o_led_col)
    else $error("collision led not lit");
  chk_col_led_hold: assert property ($fell(o_led_col) |-> col_q >= LED_HOLD_CYC - 1)
    else $error("collision led too short");
  chk_link_timeout: assert property (act_q > LINK_RX_MAX_CYC + 2 |-> !o_link_good)
    else $error("link good kept past timeout");
  chk_early_pulse: assert property (early_pulse |-> ##[1:2] !o_link_good)
    else $error("early pulse accepted");
endmodule
bind tp_link_sqe_led_timing tp_link_chk #(.LINK_RX_MIN_CYC(LINK_RX_MIN_CYC),
  .LINK_RX_MAX_CYC(LINK_RX_MAX_CYC), .LED_HOLD_CYC(LED_HOLD_CYC)) u_chk (.*);

// >>> bench/tp_link_sqe_led_timing_tb.sv
`timescale 1ns/1ps
`include "tp_link_cfg.svh"
module tp_link_sqe_led_timing_tb;
  localparam int LED = 50;
  logic i_clk_sys = 0, i_rst_b = 0, i_tx_valid = 0, i_tx_data = 0, i_tx_last = 0;
  logic i_loopback = 0, i_collision = 0, busy = 0, i_rx_link_pulse, i_rx_activity;
  logic o_tx_ready, o_tp_out_pos_main, o_tp_out_neg_main, o_tp_out_pos_predist;
  logic o_tp_out_neg_predist, o_link_good, o_sqe, o_loopback_active;
  logic o_led_rx, o_led_tx, o_led_col;
  logic [7:0] gap = 8'h00;
  int failures = 0, samples_checked = 0, run[4], runs[4][$];
  always #25 i_clk_sys = ~i_clk_sys;
  tp_link_sqe_led_timing #(.LINK_TX_CYC(40), .LINK_RX_MIN_CYC(10), .LINK_RX_MAX_CYC(100),
    .LED_HOLD_CYC(LED)) u_tp_link_sqe_led_timing (.*);
  tp_remote_station u_tp_remote_station (.i_clk_sys, .i_gap(gap), .i_busy(busy),
    .o_link_pulse(i_rx_link_pulse), .o_activity(i_rx_activity));
  wire logic [3:0] ln = {o_tp_out_neg_predist, o_tp_out_pos_predist,
                         o_tp_out_neg_main, o_tp_out_pos_main};
  always @(negedge i_clk_sys)
    for (int k = 0; k < 4; k++) begin
      if (ln[k]) run[k]++;
      else if (run[k] > 0) begin
        runs[k].push_back(run[k]);
        run[k] = 0;
      end
    end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic send(logic [7:0] bits, int n, output bit stalled);
    int t;
    stalled = 0;
    for (int i = n - 1; i >= 0; i--) begin
      i_tx_valid = 1;
      i_tx_data = bits[i];
      i_tx_last = (i == 0);
      for (t = 0; !o_tx_ready && t < 50; t++) begin
        stalled = 1;
        cyc(1);
      end
      cyc(1);
    end
    i_tx_valid = 0;
    i_tx_last = 0;
  endtask
  task automatic wait_rise(output int n);
    for (n = 0; o_tp_out_pos_main && n < 200; n++) cyc(1);
    for (; !o_tp_out_pos_main && n < 200; n++) cyc(1);
  endtask
  task automatic hi_len(ref logic s, output int n);
    for (n = 0; !s && n < 200; n++) cyc(1);
    for (n = 0; s && n < 200; n++) cyc(1);
  endtask
  // Starts just after a link pulse so none lands inside the frame
  task automatic frame(logic [7:0] bits, int n);
    int g;
    bit s;
    wait_rise(g);
    cyc(4);
    foreach (runs[k]) runs[k].delete();
    send(bits, n, s);
    check("refusal", s, 1);
    cyc(20);
  endtask
  task automatic t_idle();
    int n;
    wait_rise(n);
    foreach (runs[k]) runs[k].delete();
    wait_rise(n);
    check("link gap", n >= 38 && n <= 42, 1);
    check("link main", runs[0][0], 2);
    check("link pre", runs[2][0], 1);
    check("link pre neg", runs[3][0], 1);
  endtask
  task automatic t_alt();
    frame(8'h0a, 4);
    check("alt pos0", runs[0][0], 2);
    check("alt pos1", runs[0][1], 2);
    check("tail zero", runs[1][2], `EOP_ZERO_CYC);
    check("alt pre pos", runs[2][0], 2);
    check("alt pre neg", runs[3][2], `EOP_ZERO_CYC);
  endtask
  task automatic t_rep();
    int n;
    frame(8'h0f, 4);
    for (int i = 0; i < 3; i++) check("rep pos", runs[0][i], 1);
    check("tail one", runs[0][3], `EOP_ONE_CYC);
    hi_len(o_sqe, n);
    check("sqe window", n, 20);
  endtask
  task automatic t_led();
    int n;
    bit s;
    cyc(60);
    i_collision = 1;
    cyc(1);
    i_collision = 0;
    hi_len(o_led_col, n);
    check("col led", n >= LED - 1 && n <= LED + 1, 1);
    busy = 1;
    cyc(1);
    busy = 0;
    hi_len(o_led_rx, n);
    check("rx led", n >= LED - 1 && n <= LED + 1, 1);
    send(8'h01, 1, s);
    hi_len(o_led_tx, n);
    // Lit while busy (two halves and the one tail), then stretched
    check("tx led", n >= LED + 6 && n <= LED + 8, 1);
  endtask
  task automatic t_good();
    gap = 8'd20;
    cyc(70);
    check("good", o_link_good, 1);
    gap = 8'd5;
    cyc(12);
    check("early", o_link_good, 0);
    gap = 8'd20;
    cyc(70);
    gap = 8'h00;
    cyc(110);
    check("timeout", o_link_good, 0);
    busy = 1;
    cyc(2);
    busy = 0;
    cyc(2);
    check("activity", o_link_good, 1);
  endtask
  task automatic t_loop();
    bit s;
    i_loopback = 1;
    cyc(3);
    send(8'h01, 1, s);
    check("loop on", o_loopback_active, 1);
    cyc(20);
    i_loopback = 0;
    cyc(4);
    check("loop off", o_loopback_active, 0);
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(4);
    i_rst_b = 1;
    cyc(1);
    t_idle();
    t_alt();
    t_rep();
    t_led();
    t_good();
    t_loop();
    results();
  end
  // Whole run needs about 800 cycles
  initial begin
    cyc(6000);
    failures++;
    results();
  end
endmodule

// >>> bench/tp_remote_station.sv
`timescale 1ns/1ps
module tp_remote_station (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_gap,
  input  wire logic       i_busy,
  output logic            o_link_pulse = 1'b0,
  output logic            o_activity
);
  logic [7:0] cnt_q = 8'h00;
  assign o_activity = i_busy;
  // Idle station: one pulse every i_gap cycles, silent at zero
  always @(negedge i_clk_sys) begin
    o_link_pulse <= (i_gap != 8'h00) && (cnt_q + 8'h01 >= i_gap);
    cnt_q        <= (cnt_q + 8'h01 >= i_gap) ? 8'h00 : cnt_q + 8'h01;
  end
endmodule

// >>> rtl/tp_link_cfg.svh
`ifndef TP_LINK_CFG_SVH
`define TP_LINK_CFG_SVH
`define CLK_PERIOD_NS      50
`define LINK_TX_NOM_NS     16000000
`define LINK_RX_MIN_NS     4000000
`define LINK_RX_MAX_NS     65000000
`define LINK_MAIN_W_NS     100
`define LINK_PRE_W_NS      50
`define SQE_WAIT_NS        1000
`define SQE_WIN_NS         1000
`define LED_HOLD_NS        128000000
`define EOP_ZERO_NS        250
`define EOP_ONE_NS         300
`define HALF_BIT_NS        50
`define LINK_TX_CYC    (`LINK_TX_NOM_NS / `CLK_PERIOD_NS)
`define LINK_RX_MIN_CYC ((`LINK_RX_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINK_RX_MAX_CYC (`LINK_RX_MAX_NS / `CLK_PERIOD_NS)
`define LINK_MAIN_CYC  (`LINK_MAIN_W_NS / `CLK_PERIOD_NS)
`define SQE_WAIT_CYC   (`SQE_WAIT_NS / `CLK_PERIOD_NS)
`define SQE_WIN_CYC    (`SQE_WIN_NS / `CLK_PERIOD_NS)
`define LED_HOLD_CYC   (`LED_HOLD_NS / `CLK_PERIOD_NS)
`define EOP_ZERO_CYC   (`EOP_ZERO_NS / `CLK_PERIOD_NS)
`define EOP_ONE_CYC    (`EOP_ONE_NS / `CLK_PERIOD_NS)
`define BUF_DEPTH      2
`endif

// >>> rtl/tp_link_pkg.sv
package tp_link_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_FIRST, TX_SECOND, TX_EOP, TX_LINK} tx_state_t;
  typedef enum logic [1:0] {SQE_IDLE, SQE_WAIT, SQE_WIN} sqe_state_t;
endpackage

// >>> rtl/tp_link_sqe_led_timing.sv
`timescale 1ns/1ps
`include "tp_link_cfg.svh"
module tp_link_sqe_led_timing
  import tp_link_pkg::*;
#(
  parameter int LINK_TX_CYC     = `LINK_TX_CYC,
  parameter int LINK_RX_MIN_CYC = `LINK_RX_MIN_CYC,
  parameter int LINK_RX_MAX_CYC = `LINK_RX_MAX_CYC,
  parameter int LED_HOLD_CYC    = `LED_HOLD_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_tx_valid,
  input  wire logic i_tx_data,
  input  wire logic i_tx_last,
  output logic      o_tx_ready,
  input  wire logic i_rx_link_pulse,
  input  wire logic i_rx_activity,
  input  wire logic i_collision,
  input  wire logic i_loopback,
  output logic      o_tp_out_pos_main,
  output logic      o_tp_out_neg_main,
  output logic      o_tp_out_pos_predist,
  output logic      o_tp_out_neg_predist,
  output logic      o_link_good,
  output logic      o_sqe,
  output logic      o_loopback_active,
  output logic      o_led_rx,
  output logic      o_led_tx,
  output logic      o_led_col
);
  logic      b_valid, b_data, b_last, b_ready;
  tx_state_t tx_q, tx_d;
  logic      bit_q, bit_d, last_q, last_d;
  logic [2:0] tcnt_q, tcnt_d;
  logic [19:0] idle_q, idle_d;
  logic      pos_q, pos_d, neg_q, neg_d, ppos_q, ppos_d, pneg_q, pneg_d;
  logic      tx_busy, tx_end;
  logic [20:0] rxc_q, rxc_d;
  logic      good_q, good_d;
  sqe_state_t sqe_q, sqe_d;
  logic [4:0] scnt_q, scnt_d;
  logic      sqe_out_q, sqe_out_d, lb_q, lb_d;
  logic [2:0] led_trig;
  logic [2:0] led_on_q;

  tp_skid_buffer u_buf (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_valid   (i_tx_valid),
    .i_data    (i_tx_data),
    .i_last    (i_tx_last),
    .o_ready   (b_ready),
    .o_valid   (b_valid),
    .o_data    (b_data),
    .o_last    (b_last),
    .i_ready   (tx_q == TX_IDLE || (tx_q == TX_SECOND && !last_q))
  );

  assign tx_busy = tx_q != TX_IDLE && tx_q != TX_LINK;
  assign tx_end  = tx_q == TX_EOP && tcnt_q == 3'h1;

  // Manchester encoder, one 50 ns cycle per half bit
  always_comb begin
    tx_d   = tx_q;
    bit_d  = bit_q;
    last_d = last_q;
    tcnt_d = tcnt_q;
    idle_d = idle_q;
    pos_d  = 1'b0;
    neg_d  = 1'b0;
    case (tx_q)
      TX_IDLE: begin
        if (b_valid) begin
          tx_d   = TX_FIRST;
          bit_d  = b_data;
          last_d = b_last;
        end else if (idle_q >= 20'(LINK_TX_CYC - 1)) begin
          tx_d   = TX_LINK;
          tcnt_d = 3'(`LINK_MAIN_CYC);
          idle_d = 20'h0;
        end else begin
          idle_d = idle_q + 20'h1;
        end
      end
      TX_FIRST: begin
        // Repeated bits give 50 ns halves, alternating merge into 100 ns
        pos_d = ~bit_q;
        neg_d = bit_q;
        tx_d  = TX_SECOND;
      end
      TX_SECOND: begin
        pos_d = bit_q;
        neg_d = ~bit_q;
        if (last_q) begin
          tx_d   = TX_EOP;
          tcnt_d = bit_q ? 3'(`EOP_ONE_CYC) : 3'(`EOP_ZERO_CYC);
        end else if (b_valid) begin
          tx_d   = TX_FIRST;
          bit_d  = b_data;
          last_d = b_last;
        end else begin
          // Underrun ends frame as if last
          tx_d   = TX_EOP;
          tcnt_d = bit_q ? 3'(`EOP_ONE_CYC) : 3'(`EOP_ZERO_CYC);
        end
      end
      TX_EOP: begin
        pos_d  = pos_q;
        neg_d  = neg_q;
        tcnt_d = tcnt_q - 3'h1;
        idle_d = 20'h0;
        if (tcnt_q == 3'h1) begin
          tx_d  = TX_IDLE;
          pos_d = 1'b0;
          neg_d = 1'b0;
        end
      end
      TX_LINK: begin
        pos_d  = 1'b1;
        tcnt_d = tcnt_q - 3'h1;
        if (tcnt_q == 3'h1) begin
          tx_d  = TX_IDLE;
        end
      end
      default: tx_d = TX_IDLE;
    endcase
    // Predistortion copies main one cycle later; a link pulse drives both pos and neg high for 50 ns
    // Main is high in idle only during a link pulse's second cycle
    ppos_d = pos_q && !(ppos_q && (tx_q == TX_LINK || tx_q == TX_IDLE));
    pneg_d = neg_q || (pos_q && !ppos_q && (tx_q == TX_LINK || tx_q == TX_IDLE));
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      tx_q   <= TX_IDLE;
      bit_q  <= 1'b0;
      last_q <= 1'b0;
      tcnt_q <= 3'h0;
      idle_q <= 20'h0;
      pos_q  <= 1'b0;
      neg_q  <= 1'b0;
      ppos_q <= 1'b0;
      pneg_q <= 1'b0;
    end else begin
      tx_q   <= tx_d;
      bit_q  <= bit_d;
      last_q <= last_d;
      tcnt_q <= tcnt_d;
      idle_q <= idle_d;
      pos_q  <= pos_d;
      neg_q  <= neg_d;
      ppos_q <= ppos_d;
      pneg_q <= pneg_d;
    end
  end

  // Link integrity check on received pulses
  always_comb begin
    rxc_d  = (rxc_q < 21'(LINK_RX_MAX_CYC)) ? rxc_q + 21'h1 : rxc_q;
    good_d = good_q;
    if (i_rx_activity) begin
      rxc_d  = 21'h0;
      good_d = 1'b1;
    end else if (i_rx_link_pulse) begin
      // Pulse outside the window is not valid; counter restarts anyway
      good_d = (rxc_q >= 21'(LINK_RX_MIN_CYC)) && (rxc_q < 21'(LINK_RX_MAX_CYC));
      rxc_d  = 21'h0;
    end else if (rxc_q >= 21'(LINK_RX_MAX_CYC)) begin
      good_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rxc_q  <= 21'h0;
      good_q <= 1'b0;
    end else begin
      rxc_q  <= rxc_d;
      good_q <= good_d;
    end
  end

  // SQE test after each frame that ends while SQE is idle; loopback sampled between frames
  always_comb begin
    sqe_d     = sqe_q;
    scnt_d    = scnt_q - 5'h1;
    sqe_out_d = 1'b0;
    lb_d      = tx_busy ? lb_q : i_loopback;
    case (sqe_q)
      SQE_IDLE: begin
        scnt_d = 5'h0;
        if (tx_end) begin
          sqe_d  = SQE_WAIT;
          scnt_d = 5'(`SQE_WAIT_CYC);
        end
      end
      SQE_WAIT: begin
        if (scnt_q == 5'h1) begin
          sqe_d     = SQE_WIN;
          scnt_d    = 5'(`SQE_WIN_CYC);
          sqe_out_d = 1'b1;
        end
      end
      SQE_WIN: begin
        sqe_out_d = 1'b1;
        if (scnt_q == 5'h1) begin
          sqe_d     = SQE_IDLE;
          sqe_out_d = 1'b0;
        end
      end
      default: sqe_d = SQE_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      sqe_q     <= SQE_IDLE;
      scnt_q    <= 5'h0;
      sqe_out_q <= 1'b0;
      lb_q      <= 1'b0;
    end else begin
      sqe_q     <= sqe_d;
      scnt_q    <= scnt_d;
      sqe_out_q <= sqe_out_d;
      lb_q      <= lb_d;
    end
  end

  // LED stretchers: rx, tx, collision
  assign led_trig = {i_collision, tx_busy, i_rx_activity};

  for (genvar g = 0; g < 3; g++) begin : g_led
    logic [21:0] lc_q, lc_d;
    logic        on_d;
    always_comb begin
      lc_d = (lc_q != 22'h0) ? lc_q - 22'h1 : lc_q;
      if (led_trig[g]) begin
        lc_d = 22'(LED_HOLD_CYC);
      end
      on_d = lc_d != 22'h0;
    end
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
        lc_q        <= 22'h0;
        led_on_q[g] <= 1'b0;
      end else begin
        lc_q        <= lc_d;
        led_on_q[g] <= on_d;
      end
    end
  end

  assign o_tx_ready           = b_ready;
  assign o_tp_out_pos_main    = pos_q;
  assign o_tp_out_neg_main    = neg_q;
  assign o_tp_out_pos_predist = ppos_q;
  assign o_tp_out_neg_predist = pneg_q;
  assign o_link_good          = good_q;
  assign o_sqe                = sqe_out_q;
  assign o_loopback_active    = lb_q;
  assign o_led_rx             = led_on_q[0];
  assign o_led_tx             = led_on_q[1];
  assign o_led_col            = led_on_q[2];
endmodule

// >>> rtl/tp_skid_buffer.sv
`timescale 1ns/1ps
`include "tp_link_cfg.svh"
module tp_skid_buffer (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_valid,
  input  wire logic i_data,
  input  wire logic i_last,
  output logic      o_ready,
  output logic      o_valid,
  output logic      o_data,
  output logic      o_last,
  input  wire logic i_ready
);
  logic [1:0] data_q [2];
  logic [1:0] data_d [2];
  logic       wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;
  logic       ready_q, ready_d;

  assign push    = i_valid && ready_q;
  assign pop     = (cnt_q != 2'h0) && i_ready;
  assign o_ready = ready_q;
  assign o_valid = cnt_q != 2'h0;
  assign o_data  = data_q[rd_q][0];
  assign o_last  = data_q[rd_q][1];

  always_comb begin
    data_d = data_q;
    wr_d   = wr_q;
    rd_d   = rd_q;
    if (push) begin
      data_d[wr_q] = {i_last, i_data};
      wr_d         = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    // Registered ready, so the sender sees a flop
    ready_d = cnt_d != 2'(`BUF_DEPTH);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      data_q <= '{2'h0, 2'h0};
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      cnt_q  <= 2'h0;
      ready_q <= 1'b0;
    end else begin
      data_q <= data_d;
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      ready_q <= ready_d;
    end
  end
endmodule
